// file: host_port_pkg.sv
// shared constants for the converter's parallel host port
package host_port_pkg;
  localparam int DATA_W = 16;
  // internal clock is sys_clk divided by this ratio; strobe lasts half a period
  localparam int INTERNAL_CLOCK_DIV = 4;
  localparam int STROBE_CYCLES = INTERNAL_CLOCK_DIV / 2;
  localparam int DIV_W = 3;
  // internal clock periods per conversion result
  localparam int DECIM_RATIO = 8;
  localparam int DECIM_W = 4;
  localparam logic [DIV_W-1:0] DIV_ZERO = 3'h0;
  localparam logic [DECIM_W-1:0] DECIM_ZERO = 4'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  typedef enum logic [1:0] {
    ST_DOWN = 2'b00,
    ST_RUN = 2'b01
  } run_state_t;
endpackage : host_port_pkg

// file: strobe_gen.sv
// one-shot generator for the active-low sample-ready strobe
`timescale 1ns/100ps
module strobe_gen (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // trigger and strobe
  input wire logic fire,
  output logic sampleReadyN
);
  import host_port_pkg::*;

  logic [DIV_W-1:0] widthCnt_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      widthCnt_reg <= DIV_ZERO;
    end else if (fire) begin
      widthCnt_reg <= DIV_W'(STROBE_CYCLES);
    end else if (widthCnt_reg != DIV_ZERO) begin
      widthCnt_reg <= widthCnt_reg - 3'h1;
    end
  end

  assign sampleReadyN = (widthCnt_reg == DIV_ZERO);

  a_strobe_width: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(sampleReadyN) |-> !sampleReadyN [*2] ##1 sampleReadyN)
    else $error("strobe width not half an internal clock period");
endmodule : strobe_gen

// file: adc_host_port.sv
// parallel host port of the converter: reset, filter sync, data bus, ready strobe
`timescale 1ns/100ps
module adc_host_port (
  // clock and system reset
  input wire logic sys_clk,
  input wire logic rst,
  // device pins from the host
  input wire logic resetN,
  input wire logic syncN,
  input wire logic selectN,
  input wire logic readWriteN,
  // parallel data lines, split into three signals
  input wire logic [host_port_pkg::DATA_W-1:0] dataIn,
  output logic [host_port_pkg::DATA_W-1:0] dataOut,
  output logic dataOeN,
  // sample-ready strobe
  output logic sampleReadyN,
  // converter core side
  input wire logic [host_port_pkg::DATA_W-1:0] sampleData,
  output logic [host_port_pkg::DATA_W-1:0] writeData,
  output logic writeStrobe,
  output logic poweredDown
);
  import host_port_pkg::*;

  run_state_t state_reg;
  logic resetPin_reg;
  logic syncPin_reg;
  logic writeSeen_reg;
  logic [DIV_W-1:0] divCnt_reg;
  logic [DECIM_W-1:0] decimCnt_reg;
  logic [DATA_W-1:0] result_reg;
  logic [DATA_W-1:0] writeData_reg;
  logic resetFall;
  logic syncFall;
  logic iclkTick;
  logic resultDone;
  logic isRead;
  logic isWrite;
  logic strobeRawN;

  // one decoder for both access kinds keeps read and write exclusive
  function automatic logic accessIs(input logic selN, input logic rwN, input logic wr);
    return !selN && (rwN == wr);
  endfunction : accessIs

  assign resetFall = resetPin_reg && !resetN;
  assign syncFall = syncPin_reg && !syncN;
  assign isRead = accessIs(selectN, readWriteN, 1'b0);
  assign isWrite = accessIs(selectN, readWriteN, 1'b1);

  // previous pin levels for edge detection; inputs are synchronous
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      resetPin_reg <= 1'b1;
      syncPin_reg <= 1'b1;
    end else begin
      resetPin_reg <= resetN;
      syncPin_reg <= syncN;
    end
  end

  // low level alone holds reset, so a part started low stays down too
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_DOWN;
    end else begin
      case (state_reg)
        ST_DOWN: begin
          if (resetN) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (resetFall || !resetN) begin
            state_reg <= ST_DOWN;
          end
        end
        default: begin
          state_reg <= ST_DOWN;
        end
      endcase
    end
  end

  assign poweredDown = (state_reg != ST_RUN);

  // internal clock divider
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      divCnt_reg <= DIV_ZERO;
    end else if (poweredDown || !resetN) begin
      divCnt_reg <= DIV_ZERO;
    end else if (divCnt_reg == DIV_W'(INTERNAL_CLOCK_DIV - 1)) begin
      divCnt_reg <= DIV_ZERO;
    end else begin
      divCnt_reg <= divCnt_reg + 3'h1;
    end
  end

  assign iclkTick = !poweredDown && resetN && (divCnt_reg == DIV_W'(INTERNAL_CLOCK_DIV - 1));

  // decimation filter phase; sync restarts it so several parts align
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      decimCnt_reg <= DECIM_ZERO;
    end else if (poweredDown || !resetN || syncFall) begin
      decimCnt_reg <= DECIM_ZERO;
    end else if (iclkTick) begin
      if (decimCnt_reg == DECIM_W'(DECIM_RATIO - 1)) begin
        decimCnt_reg <= DECIM_ZERO;
      end else begin
        decimCnt_reg <= decimCnt_reg + 4'h1;
      end
    end
  end

  assign resultDone = iclkTick && !syncFall &&
    (decimCnt_reg == DECIM_W'(DECIM_RATIO - 1));

  // result latch feeding the bus
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      result_reg <= DATA_ZERO;
    end else if (poweredDown || !resetN) begin
      result_reg <= DATA_ZERO;
    end else if (resultDone) begin
      result_reg <= sampleData;
    end
  end

  strobe_gen u_strobe (
    .sys_clk(sys_clk),
    .rst(rst),
    .fire(resultDone),
    .sampleReadyN(strobeRawN)
  );

  // reset cuts a strobe in flight; the one-shot simply runs out behind the gate
  assign sampleReadyN = strobeRawN || poweredDown || !resetN;

  // bus driver: released unless a read is in progress while not powered down; a low reset pin drops it at once
  assign dataOut = result_reg;
  assign dataOeN = !(isRead && resetN && !poweredDown);

  // write capture: one strobe per select-low write access
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      writeData_reg <= DATA_ZERO;
      writeSeen_reg <= 1'b0;
    end else if (poweredDown || !resetN) begin
      writeData_reg <= DATA_ZERO;
      writeSeen_reg <= 1'b0;
    end else begin
      writeSeen_reg <= isWrite;
      if (isWrite) begin
        writeData_reg <= dataIn;
      end
    end
  end

  assign writeData = writeData_reg;
  assign writeStrobe = writeSeen_reg && selectN;

  // a strobe cut by the reset pin is allowed; one that is missing is not
  a_reset_down: assert property (@(posedge sys_clk) disable iff (rst)
    !resetN |=> poweredDown)
    else $error("part not powered down after reset low");
  a_reset_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !resetN |-> sampleReadyN && dataOeN)
    else $error("activity while reset held low");
  a_sync_restart: assert property (@(posedge sys_clk) disable iff (rst)
    syncFall && resetN && !poweredDown |=> decimCnt_reg == DECIM_ZERO)
    else $error("filter not restarted by sync");
  a_read_drive: assert property (@(posedge sys_clk) disable iff (rst)
    isRead && resetN && !poweredDown |-> !dataOeN && dataOut == result_reg)
    else $error("read without bus drive");
  a_write_take: assert property (@(posedge sys_clk) disable iff (rst)
    isWrite && resetN && !poweredDown |=> writeData == $past(dataIn))
    else $error("write data not taken");
  a_bus_release: assert property (@(posedge sys_clk) disable iff (rst)
    (selectN || readWriteN) |-> dataOeN)
    else $error("bus driven outside a read");
  a_result_strobe: assert property (@(posedge sys_clk) disable iff (rst)
    resultDone |=> (!sampleReadyN || poweredDown || !resetN) [*2] ##1 sampleReadyN)
    else $error("result without strobe");
  a_strobe_cause: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(sampleReadyN) |-> $past(resultDone))
    else $error("strobe without new result");

  // power-down, write capture, filter phase, result latch and strobe
  a_down_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    poweredDown |-> sampleReadyN && dataOeN)
    else $error("strobe or bus active while powered down");
  a_reset_clear: assert property (@(posedge sys_clk) disable iff (rst)
    !resetN |=> writeData == DATA_ZERO && dataOut == DATA_ZERO)
    else $error("data state not cleared by reset pin");
  a_run_entry: assert property (@(posedge sys_clk) disable iff (rst)
    poweredDown && resetN |=> !poweredDown)
    else $error("part stays down after reset pin released");
  a_write_ignored: assert property (@(posedge sys_clk) disable iff (rst)
    isWrite && (poweredDown || !resetN) |=> writeData == DATA_ZERO)
    else $error("write taken while in reset");
  a_write_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    writeStrobe |=> !writeStrobe)
    else $error("write strobe longer than one cycle");
  a_sync_hold: assert property (@(posedge sys_clk) disable iff (rst)
    syncFall && resetN && !poweredDown |=> !resultDone [*8])
    else $error("result too soon after sync");
  a_result_load: assert property (@(posedge sys_clk) disable iff (rst)
    resultDone |=> dataOut == $past(sampleData))
    else $error("new result not latched");
  a_strobe_single: assert property (@(posedge sys_clk) disable iff (rst)
    resultDone |-> sampleReadyN)
    else $error("new result while strobe in flight");
endmodule : adc_host_port

// file: host_model.sv
// host controller model on the far side of the parallel data lines
`timescale 1ns/100ps
module host_model (
  // clock
  input wire logic sys_clk,
  // device side of the bus
  input wire logic dataOeN,
  input wire logic [15:0] dataOut,
  // host pins
  output logic selectN,
  output logic readWriteN,
  output logic [15:0] wireBus
);
  logic [15:0] hostData;
  logic hostOeN;

  initial begin
    selectN = 1'b1;
    readWriteN = 1'b1;
    hostOeN = 1'b1;
    hostData = 16'h0000;
  end

  // floating bus shows the inverse so a stale value never passes
  always_comb wireBus = !dataOeN ? dataOut : (!hostOeN ? hostData : ~hostData);

  task automatic access(input logic wr, input logic [15:0] d, output logic [15:0] q);
    @(negedge sys_clk);
    selectN = 1'b0;
    readWriteN = wr;
    hostData = d;
    hostOeN = !wr;
    @(posedge sys_clk);
    q = wireBus;
    @(negedge sys_clk);
    selectN = 1'b1;
    hostOeN = 1'b1;
  endtask : access
endmodule : host_model

// file: tb_adc_host_port.sv
// self-checking bench for the parallel host port
`timescale 1ns/100ps
module tb_adc_host_port;
  import host_port_pkg::*;
  logic sys_clk, rst, resetN, syncN, dataOeN, sampleReadyN, writeStrobe, poweredDown;
  logic selectN, readWriteN;
  logic [DATA_W-1:0] sampleData, dataOut, writeData, wireBus, q;
  int n_fail, num_checks, n;

  adc_host_port u_adc_host_port (.sys_clk(sys_clk), .rst(rst), .resetN(resetN),
    .syncN(syncN), .selectN(selectN), .readWriteN(readWriteN), .dataIn(wireBus),
    .dataOut(dataOut), .dataOeN(dataOeN), .sampleReadyN(sampleReadyN),
    .sampleData(sampleData), .writeData(writeData), .writeStrobe(writeStrobe),
    .poweredDown(poweredDown));
  host_model u_host_model (.sys_clk(sys_clk), .dataOeN(dataOeN), .dataOut(dataOut),
    .selectN(selectN), .readWriteN(readWriteN), .wireBus(wireBus));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic end_sim();
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic wait_low(output int c);
    c = 0;
    do begin
      @(negedge sys_clk);
      c++;
    end while (sampleReadyN !== 1'b0 && c < 40);
    if (sampleReadyN !== 1'b0) begin
      chk("strobe wait", 16'h0001, 16'h0000);
      end_sim();
    end
  endtask : wait_low

  task automatic t_down();
    repeat (4) @(negedge sys_clk);
    chk("poweredDown", 16'h0001, {15'h0, poweredDown});
    u_host_model.access(1'b0, 16'h1234, q);
    chk("bus released", ~16'h1234, q);
    u_host_model.access(1'b1, 16'hbeef, q);
    chk("write while down", 16'h0000, writeData);
  endtask : t_down

  task automatic t_strobe();
    int w;
    resetN = 1'b1;
    wait_low(n);
    w = 0;
    while (sampleReadyN === 1'b0 && w < 9) begin
      @(negedge sys_clk);
      w++;
    end
    chk("strobe width", 16'h0002, w[15:0]);
    wait_low(n);
    chk("strobe gap", 16'h001e, n[15:0]);
  endtask : t_strobe

  task automatic t_read();
    u_host_model.access(1'b0, 16'h0000, q);
    chk("read data", 16'h5a3c, q);
    #1;
    chk("oe after read", 16'h0001, {15'h0, dataOeN});
  endtask : t_read

  task automatic t_write();
    u_host_model.access(1'b1, 16'hc3a5, q);
    #1;
    chk("writeData", 16'hc3a5, writeData);
    chk("writeStrobe", 16'h0001, {15'h0, writeStrobe});
    u_host_model.access(1'b1, 16'h0ff0, q);
    @(negedge sys_clk);
    chk("writeData", 16'h0ff0, writeData);
    chk("writeStrobe", 16'h0000, {15'h0, writeStrobe});
  endtask : t_write

  task automatic t_sync();
    wait_low(n);
    repeat (3) @(negedge sys_clk);
    syncN = 1'b0;
    wait_low(n);
    chk("sync phase", 16'h0021, n[15:0]);
    syncN = 1'b1;
  endtask : t_sync

  task automatic t_reset_pin();
    resetN = 1'b0;
    @(negedge sys_clk);
    chk("down on reset", 16'h0001, {15'h0, poweredDown});
    chk("write cleared", 16'h0000, writeData);
    chk("result cleared", 16'h0000, dataOut);
    repeat (40) @(negedge sys_clk);
    chk("no strobe held", 16'h0001, {15'h0, sampleReadyN});
  endtask : t_reset_pin

  initial begin
    rst = 1'b1;
    resetN = 1'b0;
    syncN = 1'b1;
    sampleData = 16'h5a3c;
    n_fail = 0;
    num_checks = 0;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    t_down();
    t_strobe();
    t_read();
    t_write();
    t_sync();
    t_reset_pin();
    end_sim();
  end
endmodule : tb_adc_host_port
